// ### src/bcr_board_control.sv
// Board control and status word of the analog input/output board.
// Assumes a single-word register port on the board clock; pins arrive
// asynchronously and are synchronised here.
// Function
// - Three-bit input mode selects sampled source
// - Input range field decodes, resets to 10V
// - Input software clock samples once, self-clears
// - Burst enable selects triggered burst acquisition
// - Burst busy reads high during burst
// - Input buffer accepts data only when enabled
// - Clear bit empties the input buffer
// - Threshold flag mirrored read-only in word
// - Sticky overflow flag until cleared or reset
// - Sticky underflow flag until written low
// - Output range field decodes, resets to 10V
// - Simultaneous bit chooses clocked output update
// - Buffered outputs bit selects output FIFO
// - Output software clock pulses once, self-clears
// - Trigger drive bit sets trigger pin direction
// - Rate-C generator runs only when enabled
// - Sample clock drive bit sets pin direction
// - Format bit selects offset binary, resets high
// - Rate-A and rate-B enables, reset low
// - Autocal starts, self-clears; pass bit behaviour
// - Swap bit exchanges demand-mode DMA channels
// - Initialize restores defaults, then self-clears
// - Flag high when count exceeds threshold
`timescale 1ns/1ps
`default_nettype none
`include "bcr_cfg.svh"
module bcr_board_control
  import bcr_pkg::*;
#(
  parameter int INIT_CYCLES =
    (`BCR_INIT_TIME_NS) / (`BCR_CLK_PERIOD_NS)
) (
  // Board clock, reset and the freeze control.
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  // Register port; a single word, read data is combinational.
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wr_data_in,
  output logic [31:0] rd_data_out,
  // Status from the acquisition side and decoded controls toward it.
  input wire bcr_status_t status_in,
  output bcr_ctrl_t ctrl_out,
  // Shared trigger pin; the enable is low while we drive it.
  input wire logic trig_pin_in,
  output logic trig_pin_out,
  output logic trig_pin_oe_n_out,
  output logic trig_in_out,
  // Sample clock pin, arranged the same way as the trigger pin.
  input wire logic sclk_pin_in,
  input wire logic sclk_drive_in,
  output logic sclk_pin_out,
  output logic sclk_pin_oe_n_out,
  output logic sclk_in_out,
  // High for the whole initialization walk.
  output logic init_busy_out
);

  // The init count must fit its twenty-bit counter and be at least one.
  initial begin
    if (INIT_CYCLES < 1 || INIT_CYCLES > 20'hfffff) begin
      $error("INIT_CYCLES out of range");
    end
  end

  localparam logic [19:0] INIT_LAST = 20'(INIT_CYCLES - 1);

  // Registered state and its next value.
  bcr_regs_t s_r;
  bcr_regs_t s_nxt;
  // Threshold comparison is combinational so the flag tracks the count.
  logic thresh_hit;
  // Write to the control word in this cycle.
  logic wr_hit;

  assign thresh_hit = status_in.ibuf_count > status_in.ibuf_threshold;
  assign wr_hit = wr_en_in && (addr_in == `BCR_OFF_CONTROL);

  // Next-state logic: bus writes, self-clearing bits, sticky flags.
  always_comb begin
    s_nxt = s_r;
    s_nxt.trig_sync = {s_r.trig_sync[0], trig_pin_in};
    s_nxt.sclk_sync = {s_r.sclk_sync[0], sclk_pin_in};
    // Single-shot clocks last exactly one cycle.
    s_nxt.word[`BCR_B_SW_CLOCK] = 1'b0;
    s_nxt.word[`BCR_B_OUT_SW_CLOCK] = 1'b0;
    s_nxt.word[`BCR_B_SW_TRIGGER] = 1'b0;
    s_nxt.word[`BCR_B_IBUF_CLEAR] = 1'b0;
    if (wr_hit) begin
      // Only writable bits change; read-only and reserved stay put.
      s_nxt.word = (s_r.word & ~(`BCR_RW_MASK)) |
        (wr_data_in & (`BCR_RW_MASK));
      // Sticky flags: a write of one leaves them, zero clears.
      s_nxt.word[`BCR_B_OVERFLOW] = s_r.word[`BCR_B_OVERFLOW] &
        wr_data_in[`BCR_B_OVERFLOW];
      s_nxt.word[`BCR_B_UNDERFLOW] = s_r.word[`BCR_B_UNDERFLOW] &
        wr_data_in[`BCR_B_UNDERFLOW];
      // Autocal is only started from idle; init starts from any state.
      s_nxt.word[`BCR_B_AUTOCAL] = s_r.word[`BCR_B_AUTOCAL] |
        (wr_data_in[`BCR_B_AUTOCAL] && s_r.state == BCR_ST_IDLE);
      s_nxt.word[`BCR_B_INIT] = s_r.word[`BCR_B_INIT] |
        wr_data_in[`BCR_B_INIT];
      if (wr_data_in[`BCR_B_AUTOCAL] && s_r.state == BCR_ST_IDLE) begin
        s_nxt.word[`BCR_B_CAL_PASS] = 1'b1;
        s_nxt.state = BCR_ST_CAL;
      end
      if (wr_data_in[`BCR_B_INIT]) begin
        s_nxt.state = BCR_ST_INIT;
        s_nxt.init_cnt = 20'h00000;
      end
    end
    // Hardware sets win over a same-cycle clear.
    if (status_in.ibuf_overflow) begin
      s_nxt.word[`BCR_B_OVERFLOW] = 1'b1;
    end
    if (status_in.ibuf_underflow) begin
      s_nxt.word[`BCR_B_UNDERFLOW] = 1'b1;
    end
    s_nxt.word[`BCR_B_BURST_BUSY] = status_in.burst_active &&
      s_r.word[`BCR_B_BURST_EN];
    s_nxt.word[`BCR_B_THRESH_FLAG] = thresh_hit;
    // Sequencer for calibration and board initialization.
    case (s_r.state)
      BCR_ST_IDLE: begin
        s_nxt.init_cnt = 20'h00000;
      end
      BCR_ST_CAL: begin
        // Completion clears the start bit and records the result.
        if (status_in.cal_done && !s_nxt.word[`BCR_B_INIT]) begin
          s_nxt.word[`BCR_B_AUTOCAL] = 1'b0;
          s_nxt.word[`BCR_B_CAL_PASS] = status_in.cal_ok;
          s_nxt.state = BCR_ST_IDLE;
        end
      end
      BCR_ST_INIT: begin
        // Holding defaults keeps software from racing the restore.
        s_nxt.word = `BCR_RESET_VALUE;
        s_nxt.word[`BCR_B_INIT] = 1'b1;
        s_nxt.init_cnt = s_r.init_cnt + 20'h00001;
        if (s_r.init_cnt == INIT_LAST) begin
          s_nxt.word[`BCR_B_INIT] = 1'b0;
          s_nxt.state = BCR_ST_IDLE;
          s_nxt.init_cnt = 20'h00000;
        end
      end
      default: begin
        s_nxt.state = BCR_ST_IDLE;
      end
    endcase
  end

  // State register; the clock enable freezes everything.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_r <= '{word: `BCR_RESET_VALUE, state: BCR_ST_IDLE,
        init_cnt: 20'h00000, trig_sync: 2'h0, sclk_sync: 2'h0};
    end else if (clk_en_in) begin
      s_r <= s_nxt;
    end
  end

  // Read data: one word, other offsets read zero.
  // Kept combinational so a read costs no wait state on the bus.
  always_comb begin
    rd_data_out = 32'h00000000;
    if (rd_en_in && addr_in == `BCR_OFF_CONTROL) begin
      rd_data_out = s_r.word;
    end
  end

  // Decoded control fields; all come straight from the register.
  always_comb begin
    ctrl_out.in_mode = bcr_in_mode_t'(s_r.word[2:0]);
    ctrl_out.in_range = bcr_range_t'(s_r.word[5:4]);
    ctrl_out.out_range = bcr_range_t'(s_r.word[17:16]);
    ctrl_out.in_sw_clock = s_r.word[`BCR_B_SW_CLOCK];
    ctrl_out.in_sw_trigger = s_r.word[`BCR_B_SW_TRIGGER];
    ctrl_out.burst_en = s_r.word[`BCR_B_BURST_EN];
    ctrl_out.ibuf_en = s_r.word[`BCR_B_IBUF_EN];
    ctrl_out.ibuf_clear = s_r.word[`BCR_B_IBUF_CLEAR];
    ctrl_out.simul_out = s_r.word[`BCR_B_SIMUL_OUT];
    ctrl_out.buf_out = s_r.word[`BCR_B_BUF_OUT];
    ctrl_out.out_sw_clock = s_r.word[`BCR_B_OUT_SW_CLOCK];
    ctrl_out.rate_a_en = s_r.word[`BCR_B_RATE_A_EN];
    ctrl_out.rate_b_en = s_r.word[`BCR_B_RATE_B_EN];
    ctrl_out.rate_c_en = s_r.word[`BCR_B_RATE_C_EN];
    ctrl_out.offset_binary = s_r.word[`BCR_B_OFFSET_BIN];
    ctrl_out.swap_dma = s_r.word[`BCR_B_SWAP_DMA];
    ctrl_out.cal_start = s_r.state == BCR_ST_CAL;
    ctrl_out.board_init = s_r.state == BCR_ST_INIT;
    ctrl_out.thresh_flag = s_r.word[`BCR_B_THRESH_FLAG];
  end

  // Pin directions: enable is low while we drive the pin.
  // The input copies are gated by the current drive bit, so a driven pin does not echo back
  // into our own trigger or clock logic while driven; levels synchronised before release still show for two cycles.
  assign trig_pin_oe_n_out = ~s_r.word[`BCR_B_TRIG_DRIVE];
  assign trig_pin_out = s_r.word[`BCR_B_SW_TRIGGER];
  assign trig_in_out = s_r.trig_sync[1] & ~s_r.word[`BCR_B_TRIG_DRIVE];
  assign sclk_pin_oe_n_out = ~s_r.word[`BCR_B_SCLK_DRIVE];
  assign sclk_pin_out = sclk_drive_in;
  assign sclk_in_out = s_r.sclk_sync[1] & ~s_r.word[`BCR_B_SCLK_DRIVE];
  assign init_busy_out = s_r.state == BCR_ST_INIT;

  // Software clocks stay high for one cycle only.
  a_sw_clock_pulse: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    clk_en_in && s_r.word[`BCR_B_SW_CLOCK] && !wr_hit |=>
      !s_r.word[`BCR_B_SW_CLOCK])
    else $error("input sw clock did not clear");
  a_out_clock_pulse: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    clk_en_in && s_r.word[`BCR_B_OUT_SW_CLOCK] && !wr_hit |=>
      !s_r.word[`BCR_B_OUT_SW_CLOCK])
    else $error("output sw clock did not clear");
  a_overflow_sticky: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    clk_en_in && status_in.ibuf_overflow && s_r.state != BCR_ST_INIT |=>
      s_r.word[`BCR_B_OVERFLOW])
    else $error("overflow not captured");
  a_underflow_hold: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    clk_en_in && s_r.word[`BCR_B_UNDERFLOW] && !wr_hit &&
      s_r.state != BCR_ST_INIT |=> s_r.word[`BCR_B_UNDERFLOW])
    else $error("underflow lost");
  a_thresh_track: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    clk_en_in && s_r.state != BCR_ST_INIT |=>
      s_r.word[`BCR_B_THRESH_FLAG] == $past(thresh_hit))
    else $error("threshold flag wrong");
  a_trig_direction: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    clk_en_in && wr_hit && s_r.state != BCR_ST_INIT |=>
      trig_pin_oe_n_out == !$past(wr_data_in[`BCR_B_TRIG_DRIVE]))
    else $error("trigger pin direction wrong");
  a_init_restore: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    clk_en_in && wr_hit && wr_data_in[`BCR_B_INIT] ##1 clk_en_in |=>
      s_r.word[29:0] == 30'(`BCR_RESET_VALUE))
    else $error("defaults not restored");
  a_ro_ignored: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    clk_en_in && wr_hit && s_r.state == BCR_ST_IDLE &&
      !wr_data_in[`BCR_B_AUTOCAL] && !wr_data_in[`BCR_B_INIT] |=>
      s_r.word[`BCR_B_CAL_PASS] == $past(s_r.word[`BCR_B_CAL_PASS]))
    else $error("read-only pass bit written");
  a_cal_pass_start: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    clk_en_in && wr_hit && wr_data_in[`BCR_B_AUTOCAL] &&
      !wr_data_in[`BCR_B_INIT] && s_r.state == BCR_ST_IDLE |=>
      s_r.word[`BCR_B_CAL_PASS] && s_r.state == BCR_ST_CAL)
    else $error("pass bit not set at cal start");

  // Busy follows an active burst while bursts are enabled.
  a_busy_set: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    clk_en_in && s_r.state != BCR_ST_INIT && status_in.burst_active &&
      s_r.word[`BCR_B_BURST_EN] |=> s_r.word[`BCR_B_BURST_BUSY])
    else $error("burst busy not set");

  // Busy drops once the burst is over.
  a_busy_clear: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    clk_en_in && !status_in.burst_active |=>
      !s_r.word[`BCR_B_BURST_BUSY])
    else $error("burst busy not cleared");

  // A write of zero clears overflow when no new overflow arrives.
  a_overflow_clear: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    clk_en_in && wr_hit && !wr_data_in[`BCR_B_OVERFLOW] &&
      !status_in.ibuf_overflow && s_r.state != BCR_ST_INIT |=>
      !s_r.word[`BCR_B_OVERFLOW])
    else $error("overflow not cleared");

  // Completion drops the start bit and records the outcome.
  a_cal_done: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    clk_en_in && s_r.state == BCR_ST_CAL && status_in.cal_done &&
      !(wr_hit && wr_data_in[`BCR_B_INIT]) |=>
      !s_r.word[`BCR_B_AUTOCAL] &&
      s_r.word[`BCR_B_CAL_PASS] == $past(status_in.cal_ok))
    else $error("autocal did not complete");

  // Every bit but initialize holds its default during the walk.
  a_init_hold: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    clk_en_in && s_r.state == BCR_ST_INIT |=>
      s_r.word[30:0] == 31'(`BCR_RESET_VALUE))
    else $error("defaults not held in init");

  // The last count lets go of the initialize bit and the busy flag.
  a_init_release: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    clk_en_in && s_r.state == BCR_ST_INIT && s_r.init_cnt == INIT_LAST |=>
      !s_r.word[`BCR_B_INIT] && !init_busy_out)
    else $error("init did not release");

  // The buffer clear strobe lasts a single cycle.
  a_clear_pulse: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    clk_en_in && s_r.word[`BCR_B_IBUF_CLEAR] && !wr_hit |=>
      !s_r.word[`BCR_B_IBUF_CLEAR])
    else $error("buffer clear did not end");

  // A written sample clock direction reaches the pin enable.
  a_sclk_direction: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    clk_en_in && wr_hit && s_r.state != BCR_ST_INIT |=>
      sclk_pin_oe_n_out == !$past(wr_data_in[`BCR_B_SCLK_DRIVE]))
    else $error("sample clock direction wrong");

  // While we drive the trigger pin, our own level is not an input.
  a_trig_gate: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    !trig_pin_oe_n_out |-> !trig_in_out)
    else $error("driven trigger seen as input");

  // A written input mode shows on the decoded control next cycle.
  a_mode_follow: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    clk_en_in && wr_hit && s_r.state != BCR_ST_INIT |=>
      ctrl_out.in_mode == $past(wr_data_in[2:0]))
    else $error("input mode not taken");

  // Both range fields take the written codes, reserved code too.
  a_range_follow: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    clk_en_in && wr_hit && s_r.state != BCR_ST_INIT |=>
      s_r.word[5:4] == $past(wr_data_in[5:4]) &&
      s_r.word[17:16] == $past(wr_data_in[17:16]))
    else $error("range fields not taken");

  // Reserved low bits never pick up written ones.
  a_reserved_zero: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    clk_en_in && wr_hit |=>
      s_r.word[3] == 1'b0 && s_r.word[7:6] == 2'h0)
    else $error("reserved bits not zero");

endmodule
`default_nettype wire

// ### src/bcr_cfg.svh
// Offsets, field positions, reset values and timing counts of the board
// control register block.
// Assumes inclusion by its bare name from the package and the design file.
`ifndef BCR_CFG_SVH
`define BCR_CFG_SVH
`define BCR_OFF_CONTROL 8'h00
`define BCR_RESET_VALUE 32'h22020020
`define BCR_RW_MASK 32'h4fff3b37
`define BCR_B_SW_CLOCK 8
`define BCR_B_BURST_EN 9
`define BCR_B_BURST_BUSY 10
`define BCR_B_SW_TRIGGER 11
`define BCR_B_IBUF_EN 12
`define BCR_B_IBUF_CLEAR 13
`define BCR_B_THRESH_FLAG 14
`define BCR_B_OVERFLOW 15
`define BCR_B_SIMUL_OUT 18
`define BCR_B_BUF_OUT 19
`define BCR_B_OUT_SW_CLOCK 20
`define BCR_B_TRIG_DRIVE 21
`define BCR_B_RATE_C_EN 22
`define BCR_B_UNDERFLOW 23
`define BCR_B_SCLK_DRIVE 24
`define BCR_B_OFFSET_BIN 25
`define BCR_B_RATE_A_EN 26
`define BCR_B_RATE_B_EN 27
`define BCR_B_AUTOCAL 28
`define BCR_B_CAL_PASS 29
`define BCR_B_SWAP_DMA 30
`define BCR_B_INIT 31
`define BCR_INIT_TIME_NS 3000000
`define BCR_CLK_PERIOD_NS 5
`endif

// ### src/bcr_pkg.sv
// Types shared by the board control register block.
// Assumes the constants header is on the include path.
`include "bcr_cfg.svh"
package bcr_pkg;
  // Input source selection.
  typedef enum logic [2:0] {
    BCR_IN_DIFF = 3'h0,
    BCR_IN_SINGLE = 3'h1,
    BCR_IN_ZERO = 3'h2,
    BCR_IN_VREF = 3'h3,
    BCR_IN_LOOP0 = 3'h4,
    BCR_IN_LOOP1 = 3'h5,
    BCR_IN_LOOP2 = 3'h6,
    BCR_IN_LOOP3 = 3'h7
  } bcr_in_mode_t;
  // Voltage range selection.
  typedef enum logic [1:0] {
    BCR_RNG_2V5 = 2'h0,
    BCR_RNG_5V = 2'h1,
    BCR_RNG_10V = 2'h2,
    BCR_RNG_RSVD = 2'h3
  } bcr_range_t;
  // Sequencer states for calibration and initialization.
  typedef enum logic [1:0] {
    BCR_ST_IDLE = 2'h0,
    BCR_ST_CAL = 2'h1,
    BCR_ST_INIT = 2'h2
  } bcr_state_t;
  // Status arriving from the acquisition and buffer logic.
  typedef struct packed {
    logic burst_active;
    logic [18:0] ibuf_count;
    logic [18:0] ibuf_threshold;
    logic ibuf_overflow;
    logic ibuf_underflow;
    logic cal_done;
    logic cal_ok;
  } bcr_status_t;
  // Decoded controls toward the rest of the board.
  typedef struct packed {
    bcr_in_mode_t in_mode;
    bcr_range_t in_range;
    bcr_range_t out_range;
    logic in_sw_clock;
    logic in_sw_trigger;
    logic burst_en;
    logic ibuf_en;
    logic ibuf_clear;
    logic simul_out;
    logic buf_out;
    logic out_sw_clock;
    logic rate_a_en;
    logic rate_b_en;
    logic rate_c_en;
    logic offset_binary;
    logic swap_dma;
    logic cal_start;
    logic board_init;
    logic thresh_flag;
  } bcr_ctrl_t;
  // Whole module state.
  typedef struct packed {
    logic [31:0] word;
    bcr_state_t state;
    logic [19:0] init_cnt;
    logic [1:0] trig_sync;
    logic [1:0] sclk_sync;
  } bcr_regs_t;
endpackage

// ### sim/bcr_testbench.sv
// Self-checking bench for the board control word block.
// Assumes the package and constants header are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bcr_pkg::*;
  // Register port, status and pin stimulus driven by the bench.
  logic clk_sys_in, resetn_in, clk_en_in, wr_en_in, rd_en_in;
  logic [7:0] addr_in;
  logic [31:0] wr_data_in, rd_data_out;
  bcr_status_t status_in;
  bcr_ctrl_t ctrl_out;
  logic trig_pin_in, trig_pin_out, trig_pin_oe_n_out, trig_in_out;
  logic sclk_pin_in, sclk_drive_in, sclk_pin_out, sclk_pin_oe_n_out;
  logic sclk_in_out, init_busy_out;
  int bad_count = 0;
  int n_checks = 0;
  // A short init count keeps the initialization walk brief.
  bcr_board_control #(.INIT_CYCLES(4)) dut (
    .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .clk_en_in(clk_en_in),
    .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .rd_data_out(rd_data_out),
    .status_in(status_in), .ctrl_out(ctrl_out), .trig_pin_in(trig_pin_in),
    .trig_pin_out(trig_pin_out), .trig_pin_oe_n_out(trig_pin_oe_n_out),
    .trig_in_out(trig_in_out), .sclk_pin_in(sclk_pin_in),
    .sclk_drive_in(sclk_drive_in), .sclk_pin_out(sclk_pin_out),
    .sclk_pin_oe_n_out(sclk_pin_oe_n_out), .sclk_in_out(sclk_in_out),
    .init_busy_out(init_busy_out));
  // The 200 MHz board clock.
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  // Compares one value and counts it; four-state equality catches X.
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One write; returns at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    wr_en_in <= 1'b1;
    addr_in <= a;
    wr_data_in <= d;
    @(posedge clk_sys_in);
    wr_en_in <= 1'b0;
  endtask
  // One read; the data is combinational, so sample once settled.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys_in);
    rd_en_in <= 1'b1;
    addr_in <= a;
    #1;
    chk("read word", e, rd_data_out);
    @(posedge clk_sys_in);
    rd_en_in <= 1'b0;
  endtask
  task automatic done(input string s);
    $display("Test %s finished", s);
  endtask
  // Runs one calibration and lets it end with the given outcome.
  task automatic cal(input logic ok);
    wr(8'h00, 32'h10000000);
    #1;
    chk("cal_start", 32'h1, {31'h0, ctrl_out.cal_start});
    rd(8'h00, 32'h30000000);
    status_in.cal_done <= 1'b1;
    status_in.cal_ok <= ok;
    @(posedge clk_sys_in);
    status_in.cal_done <= 1'b0;
    rd(8'h00, {2'h0, ok, 29'h0});
  endtask
  // The single place where the run ends.
  task automatic final_report();
    $display("Checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Cuts a hang short; the tests need well under a thousand cycles.
  initial begin
    #20000;
    bad_count++;
    $display("ERROR watchdog expected finish seen timeout");
    final_report();
  end
  // Main sequence of tests.
  initial begin
    resetn_in = 1'b0;
    clk_en_in = 1'b1;
    wr_en_in = 1'b0;
    rd_en_in = 1'b0;
    addr_in = 8'h00;
    wr_data_in = 32'h0;
    status_in = '0;
    trig_pin_in = 1'b0;
    sclk_pin_in = 1'b0;
    sclk_drive_in = 1'b0;
    repeat (6) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    rd(8'h00, 32'h22020020);
    rd(8'h04, 32'h0);
    wr(8'h04, 32'hffffffff);
    rd(8'h00, 32'h22020020);
    done("reset");
    // Every writable bit set, but neither autocal nor initialize.
    wr(8'h00, 32'h6fffffff);
    #1;
    chk("pulses", 32'h1f, {27'h0, trig_pin_out, ctrl_out.in_sw_clock,
        ctrl_out.out_sw_clock, ctrl_out.ibuf_clear,
        ctrl_out.in_sw_trigger});
    @(posedge clk_sys_in);
    #1;
    chk("pulses end", 32'h0, {27'h0, trig_pin_out, ctrl_out.in_sw_clock,
        ctrl_out.out_sw_clock, ctrl_out.ibuf_clear,
        ctrl_out.in_sw_trigger});
    chk("levels", 32'h1ff, {23'h0, ctrl_out.burst_en, ctrl_out.ibuf_en,
        ctrl_out.simul_out, ctrl_out.buf_out, ctrl_out.rate_a_en,
        ctrl_out.rate_b_en, ctrl_out.rate_c_en, ctrl_out.offset_binary,
        ctrl_out.swap_dma});
    chk("oe_n driving", 32'h0, {30'h0, trig_pin_oe_n_out,
        sclk_pin_oe_n_out});
    sclk_drive_in <= 1'b1;
    rd(8'h00, 32'h6f6f1237);
    chk("sclk out", 32'h1, {31'h0, sclk_pin_out});
    done("all ones");
    // Pins as inputs follow the outside level after synchronising.
    wr(8'h00, 32'h0);
    trig_pin_in <= 1'b1;
    sclk_pin_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    #1;
    chk("pins in", 32'hf, {28'h0, trig_in_out, sclk_in_out,
        trig_pin_oe_n_out, sclk_pin_oe_n_out});
    done("pins");
    // Every mode and range code, ranges following the low bits.
    for (int i = 0; i < 8; i++) begin
      wr(8'h00, {14'h0, i[1:0], 10'h0, i[1:0], 1'b0, i[2:0]});
      #1;
      chk("mode range", {24'h0, i[1:0], i[1:0], 1'b0, i[2:0]},
          {24'h0, ctrl_out.out_range, ctrl_out.in_range, 1'b0,
          ctrl_out.in_mode});
    end
    // A write while the clock enable is low must be lost.
    clk_en_in <= 1'b0;
    wr(8'h00, 32'h00000003);
    clk_en_in <= 1'b1;
    rd(8'h00, 32'h20030037);
    done("modes");
    // Sticky flags: set by a pulse, kept by writing one, cleared by zero.
    wr(8'h00, 32'h0);
    status_in.ibuf_overflow <= 1'b1;
    status_in.ibuf_underflow <= 1'b1;
    @(posedge clk_sys_in);
    status_in.ibuf_overflow <= 1'b0;
    status_in.ibuf_underflow <= 1'b0;
    rd(8'h00, 32'h20808000);
    wr(8'h00, 32'h00808000);
    rd(8'h00, 32'h20808000);
    wr(8'h00, 32'h0);
    rd(8'h00, 32'h20000000);
    done("flags");
    // Busy and threshold flags, with count one above then equal.
    wr(8'h00, 32'h00000200);
    status_in.burst_active <= 1'b1;
    status_in.ibuf_count <= 19'h00006;
    status_in.ibuf_threshold <= 19'h00005;
    repeat (2) @(posedge clk_sys_in);
    rd(8'h00, 32'h20004600);
    chk("thresh ctrl", 32'h1, {31'h0, ctrl_out.thresh_flag});
    status_in.burst_active <= 1'b0;
    status_in.ibuf_count <= 19'h00005;
    repeat (2) @(posedge clk_sys_in);
    rd(8'h00, 32'h20000200);
    chk("thresh ctrl", 32'h0, {31'h0, ctrl_out.thresh_flag});
    done("status");
    cal(1'b0);
    cal(1'b1);
    done("autocal");
    // Initialization restores defaults and then lets go.
    wr(8'h00, 32'h8f000000);
    #1;
    chk("init busy", 32'h3, {30'h0, init_busy_out,
        ctrl_out.board_init});
    for (int k = 0; k < 50 && init_busy_out !== 1'b0; k++) begin
      @(posedge clk_sys_in);
      #1;
    end
    chk("init end", 32'h0, {30'h0, init_busy_out,
        ctrl_out.board_init});
    rd(8'h00, 32'h22020020);
    done("init");
    final_report();
  end
endmodule
`default_nettype wire
